// *** rtl/cmm_pkg.sv ***
package cmm_pkg;

   // Requesters: two hosts and the buffer channel.
   localparam int NUM_REQ = 3;
   localparam int WORD_W  = 12;

   // Base timing at the system clock.
   localparam int CLK_PERIOD_NS = 50;
   localparam int PULSE_NS      = 200;
   localparam int PULSE_CLKS    = PULSE_NS / CLK_PERIOD_NS;
   localparam int CYCLE_NS      = 6400;
   localparam int CYCLE_PULSES  = CYCLE_NS / PULSE_NS;
   localparam int QUARTER_NS    = 1600;
   localparam int RESYNC_CLKS   = QUARTER_NS / CLK_PERIOD_NS;
   localparam int READ_NS       = 1800;
   localparam int WRITE_START_NS = 2800;
   localparam int WRITE_NS      = 1800;
   localparam int PATH_LEAD_NS  = 400;
   localparam int ADDR_LEAD_NS  = 200;
   localparam int POWER_DELAY_MS = 4;
   localparam int POWER_DELAY_CLKS =
      POWER_DELAY_MS * 1000000 / CLK_PERIOD_NS;

   // Pulse indices within the 32-pulse storage cycle.
   localparam logic [4:0] PULSE_LAST = 5'(CYCLE_PULSES - 1);
   localparam logic [4:0] READ_LAST  = 5'(READ_NS / PULSE_NS - 1);
   localparam logic [4:0] WRITE_FIRST = 5'(WRITE_START_NS / PULSE_NS);
   localparam logic [4:0] WRITE_LAST =
      5'((WRITE_START_NS + WRITE_NS) / PULSE_NS - 1);
   localparam logic [4:0] INHIBIT_FIRST = 5'(WRITE_START_NS / PULSE_NS - 1);
   localparam logic [4:0] DIVERT_END = 5'(3 * QUARTER_NS / PULSE_NS);
   localparam logic [4:0] LOCK_RELEASE = 5'd27;
   localparam logic [1:0] PULSE_CNT_LAST = 2'(PULSE_CLKS - 1);
   localparam logic [4:0] PATH_OPEN =
      5'(RESYNC_CLKS - PATH_LEAD_NS / CLK_PERIOD_NS);
   localparam logic [4:0] ADDR_LOAD =
      5'(RESYNC_CLKS - ADDR_LEAD_NS / CLK_PERIOD_NS);

   // Register map, byte addresses.
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_ADDR   = 12'h008;
   localparam logic [11:0] REG_DATA   = 12'h00c;
   localparam int CTRL_FAULT_RST = 0;
   localparam int CTRL_HOLD      = 1;
   localparam logic CTRL_HOLD_RST = 1'b0;
   localparam int ST_BUSY  = 0;
   localparam int ST_FAULT = 1;
   localparam int ST_PGOOD = 2;
   localparam int ST_GRANT = 4;
   localparam int ST_PULSE = 8;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } cmm_state_e;

   typedef struct packed {
      logic              select;
      logic              evenResync;
      logic [WORD_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } cmm_req_s;

   typedef struct packed {
      logic [7:0]        horizDriver;
      logic [7:0]        horizDiverterSet;
      logic [7:0]        vertDriver;
      logic [7:0]        vertDiverterSet;
      logic              readTerm;
      logic              writeTerm;
      logic [WORD_W-1:0] inhibit;
   } cmm_drive_s;

   // One-hot decode of an octal address group.
   function automatic logic [7:0] oct_decode(input logic [2:0] v);
      return 8'h01 << v;
   endfunction

endpackage

// *** rtl/cmm_power_monitor.sv ***
`timescale 1ns/1ps
module cmm_power_monitor #(
   parameter int DELAY_CLKS = cmm_pkg::POWER_DELAY_CLKS
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic powerLow,
   output logic      powerGood,
   output logic      scanEnable
);

   logic [16:0] lowCnt_q;
   logic [16:0] lowCnt_d;
   logic [16:0] upCnt_q;
   logic [16:0] upCnt_d;
   logic        good_q;
   logic        good_d;

   // A low level must persist for the whole delay before power is bad, so
   // brief monitor pulses are absorbed; the start-up count holds off
   // the scanner after power-on.
   always_comb begin
      lowCnt_d = powerLow ? lowCnt_q : 17'h00000;
      if (powerLow && lowCnt_q != 17'(DELAY_CLKS)) begin
         lowCnt_d = lowCnt_q + 17'h00001;
      end
      upCnt_d = upCnt_q;
      if (upCnt_q != 17'(DELAY_CLKS)) begin
         upCnt_d = upCnt_q + 17'h00001;
      end
      good_d = lowCnt_d != 17'(DELAY_CLKS);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lowCnt_q <= 17'h00000;
         upCnt_q  <= 17'h00000;
         good_q   <= 1'b1;
      end else begin
         lowCnt_q <= lowCnt_d;
         upCnt_q  <= upCnt_d;
         good_q   <= good_d;
      end
   end

   assign powerGood  = good_q;
   assign scanEnable = upCnt_q == 17'(DELAY_CLKS);

endmodule

// *** rtl/cmm_scanner.sv ***
`timescale 1ns/1ps
module cmm_scanner (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       releasePulse,
   input  wire logic [2:0] request,
   output logic [2:0]      grant,
   output logic            fault
);

   logic [2:0] ring_q;
   logic [2:0] ring_d;
   logic [2:0] grant_q;
   logic [2:0] grant_d;
   logic       fault_q;
   logic       fault_d;

   // The pulse circulates while no grant is held and stops on the first
   // requester it meets, so only one request is taken per cycle.
   always_comb begin
      ring_d  = ring_q;
      grant_d = grant_q;
      fault_d = 1'b0;
      if (!enable) begin
         ring_d  = 3'b001;
         grant_d = 3'b000;
      end else if (!$onehot(ring_q)) begin
         fault_d = 1'b1;
         ring_d  = 3'b001;
         grant_d = 3'b000;
      end else if (releasePulse) begin
         grant_d = 3'b000;
      end else if (grant_q == 3'b000) begin
         if (|(ring_q & request)) begin
            grant_d = ring_q & request;
         end else begin
            ring_d = {ring_q[1:0], ring_q[2]};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ring_q  <= 3'b001;
         grant_q <= 3'b000;
         fault_q <= 1'b0;
      end else begin
         ring_q  <= ring_d;
         grant_q <= grant_d;
         fault_q <= fault_d;
      end
   end

   assign grant = grant_q;
   assign fault = fault_q;

   grant_onehot_a: assert property (@(posedge clk_sys) disable iff (rst)
      grant_q != 3'b000 |-> $onehot(grant_q))
      else $error("Scanner granted more than one requester.");

endmodule

// *** rtl/cmm_module_control.sv ***
`timescale 1ns/1ps
module cmm_module_control #(
   parameter int POWER_DELAY_CLKS = cmm_pkg::POWER_DELAY_CLKS
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire cmm_pkg::cmm_req_s [2:0] req,
   input  wire logic [11:0]             senseData,
   input  wire logic                    powerLow,
   input  wire logic                    faultResetIn,
   output logic [2:0]                   availableN,
   output logic [2:0]                   resumeN,
   output logic [11:0]                  readData,
   output logic                         dataPathEn,
   output cmm_pkg::cmm_drive_s          drive,
   output logic                         timingFault,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic                    hready,
   input  wire logic [31:0]             hwdata,
   output logic                         hreadyout,
   output logic [31:0]                  hrdata,
   output logic                         hresp
);

   cmm_pkg::cmm_state_e state_q;
   cmm_pkg::cmm_state_e state_d;
   cmm_pkg::cmm_drive_s drive_q;
   cmm_pkg::cmm_drive_s drive_d;
   cmm_pkg::cmm_req_s   sel;
   logic [1:0]  tick_q;
   logic [1:0]  tick_d;
   logic [4:0]  pulse_q;
   logic [4:0]  pulse_d;
   logic [2:0][4:0] resyncCnt_q;
   logic [2:0][4:0] resyncCnt_d;
   logic [4:0]  resyncSel;
   logic [11:0] addr_q;
   logic [11:0] addr_d;
   logic [11:0] zReg_q;
   logic [11:0] zReg_d;
   logic [11:0] wReg_q;
   logic [11:0] wReg_d;
   logic        read_q;
   logic        read_d;
   logic        write_q;
   logic        write_d;
   logic        inhibit_q;
   logic        inhibit_d;
   logic        divert_q;
   logic        divert_d;
   logic        pathEn_q;
   logic        pathEn_d;
   logic        fault_q;
   logic        fault_d;
   logic [2:0]  avail_q;
   logic [2:0]  grant;
   logic [2:0]  selectReq;
   logic        scanFault;
   logic        powerGood;
   logic        scanEnable;
   logic        pulseEnd;
   logic        releasePulse;
   logic        faultReset;
   logic        hold_q;
   logic        hold_d;
   logic        wrPend_q;
   logic        wrPend_d;
   logic [11:0] wrAddr_q;
   logic [11:0] wrAddr_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic        busAccess;

   cmm_power_monitor #(
      .DELAY_CLKS (POWER_DELAY_CLKS)
   ) u_power (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .powerLow   (powerLow),
      .powerGood  (powerGood),
      .scanEnable (scanEnable)
   );

   // Select codes are sampled per requester; the fault latch and the
   // software hold keep the scanner parked.
   always_comb begin
      for (int i = 0; i < cmm_pkg::NUM_REQ; i++) begin
         selectReq[i] = req[i].select;
      end
   end

   cmm_scanner u_scanner (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .enable       (scanEnable && !fault_q && !hold_q),
      .releasePulse (releasePulse),
      .request      (selectReq),
      .grant        (grant),
      .fault        (scanFault)
   );

   // The granted requester's signals, muxed by the one-hot grant. Each
   // requester has its own resync phase counter, because its last resync
   // usually falls before the grant and would be missed otherwise.
   always_comb begin
      sel       = '0;
      resyncSel = 5'd0;
      for (int i = 0; i < cmm_pkg::NUM_REQ; i++) begin
         if (grant[i]) begin
            sel       = req[i];
            resyncSel = resyncCnt_q[i];
         end
      end
   end

   assign pulseEnd = tick_q == cmm_pkg::PULSE_CNT_LAST;
   assign releasePulse = state_q == cmm_pkg::ST_RUN && pulseEnd
      && pulse_q == cmm_pkg::LOCK_RELEASE - 5'd1;
   assign faultReset = faultResetIn ||
      (wrPend_q && wrAddr_q == cmm_pkg::REG_CTRL &&
       hwdata[cmm_pkg::CTRL_FAULT_RST]);

   // Timing chain: pulse counter in steps of four clocks, started by the
   // requester's resync so the module runs one quarter behind it.
   always_comb begin
      state_d     = state_q;
      tick_d      = tick_q + 2'd1;
      pulse_d     = pulse_q;
      for (int i = 0; i < cmm_pkg::NUM_REQ; i++) begin
         resyncCnt_d[i] = req[i].evenResync ? 5'd0 : resyncCnt_q[i] + 5'd1;
      end
      addr_d      = addr_q;
      pathEn_d    = 1'b0;
      case (state_q)
         cmm_pkg::ST_IDLE: begin
            tick_d = 2'd0;
            if (grant != 3'b000) begin
               state_d = cmm_pkg::ST_WAIT;
            end
         end
         cmm_pkg::ST_WAIT: begin
            tick_d  = 2'd0;
            pulse_d = 5'd0;
            pathEn_d = resyncSel >= cmm_pkg::PATH_OPEN
               || sel.evenResync;
            if (resyncSel == cmm_pkg::ADDR_LOAD) begin
               addr_d = sel.addr;
            end
            if (sel.evenResync) begin
               state_d = cmm_pkg::ST_RUN;
            end
         end
         cmm_pkg::ST_RUN: begin
            pathEn_d = pulse_q < cmm_pkg::DIVERT_END;
            if (pulseEnd) begin
               pulse_d = pulse_q + 5'd1;
               if (pulse_q == cmm_pkg::PULSE_LAST) begin
                  pulse_d = 5'd0;
                  state_d = (grant != 3'b000) ? cmm_pkg::ST_WAIT
                                              : cmm_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            state_d = cmm_pkg::ST_IDLE;
         end
      endcase
      if (fault_q) begin
         state_d  = cmm_pkg::ST_IDLE;
         pulse_d  = 5'd0;
         addr_d   = 12'h000;
         pathEn_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q     <= cmm_pkg::ST_IDLE;
         tick_q      <= 2'd0;
         pulse_q     <= 5'd0;
         resyncCnt_q <= '0;
         addr_q      <= 12'h000;
         pathEn_q    <= 1'b0;
      end else begin
         state_q     <= state_d;
         tick_q      <= tick_d;
         pulse_q     <= pulse_d;
         resyncCnt_q <= resyncCnt_d;
         addr_q      <= addr_d;
         pathEn_q    <= pathEn_d;
      end
   end

   // Phase flops and core drive. The cycle never depends on the kind of
   // reference, since restore data always comes back from the requester.
   always_comb begin
      logic run;
      run       = state_q == cmm_pkg::ST_RUN && !fault_q;
      read_d    = run && pulse_q <= cmm_pkg::READ_LAST;
      write_d   = run && pulse_q >= cmm_pkg::WRITE_FIRST
                  && pulse_q <= cmm_pkg::WRITE_LAST;
      inhibit_d = run && pulse_q >= cmm_pkg::INHIBIT_FIRST
                  && pulse_q <= cmm_pkg::WRITE_LAST;
      divert_d  = run && pulse_q < cmm_pkg::DIVERT_END;
      zReg_d    = zReg_q;
      wReg_d    = wReg_q;
      if (run && pulseEnd && pulse_q == cmm_pkg::READ_LAST) begin
         zReg_d = senseData;
      end
      if (run && pathEn_q && pulse_q == cmm_pkg::INHIBIT_FIRST - 5'd1) begin
         wReg_d = sel.wdata;
      end
      drive_d = '0;
      if (divert_d) begin
         drive_d.horizDiverterSet = cmm_pkg::oct_decode(addr_q[8:6]);
         drive_d.vertDiverterSet  = cmm_pkg::oct_decode(addr_q[2:0]);
      end
      if (read_d || write_d) begin
         drive_d.horizDriver = cmm_pkg::oct_decode(addr_q[11:9]);
         drive_d.vertDriver  = cmm_pkg::oct_decode(addr_q[5:3]);
         drive_d.readTerm    = read_d;
         drive_d.writeTerm   = write_d && !read_d;
      end
      if (inhibit_d && (read_d || write_d)) begin
         drive_d.inhibit = ~wReg_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         read_q    <= 1'b0;
         write_q   <= 1'b0;
         inhibit_q <= 1'b0;
         divert_q  <= 1'b0;
         zReg_q    <= 12'h000;
         wReg_q    <= 12'h000;
         drive_q   <= '0;
      end else begin
         read_q    <= read_d;
         write_q   <= write_d;
         inhibit_q <= inhibit_d;
         divert_q  <= divert_d;
         zReg_q    <= zReg_d;
         wReg_q    <= wReg_d;
         drive_q   <= drive_d;
      end
   end

   // Fault latch: a new fault wins over a reset arriving in the same cycle.
   always_comb begin
      fault_d = fault_q;
      if (faultReset) begin
         fault_d = 1'b0;
      end
      if (!powerGood || scanFault) begin
         fault_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fault_q <= 1'b1;
         avail_q <= 3'b000;
      end else begin
         fault_q <= fault_d;
         avail_q <= fault_q ? 3'b000 : grant;
      end
   end

   assign availableN  = ~avail_q;
   assign resumeN     = ~avail_q;
   assign readData    = zReg_q;
   assign dataPathEn  = pathEn_q;
   assign drive       = drive_q;
   assign timingFault = fault_q;

   // Bus slave with no wait states; read data is registered in the address
   // phase so it stands for the whole data phase.
   assign busAccess = hsel && htrans[1] && hready;

   always_comb begin
      wrPend_d = busAccess && hwrite;
      wrAddr_d = busAccess ? haddr[11:0] : wrAddr_q;
      hold_d   = hold_q;
      hrdata_d = hrdata_q;
      if (wrPend_q && wrAddr_q == cmm_pkg::REG_CTRL) begin
         hold_d = hwdata[cmm_pkg::CTRL_HOLD];
      end
      if (busAccess && !hwrite) begin
         hrdata_d = 32'h00000000;
         case (haddr[11:0])
            cmm_pkg::REG_CTRL: begin
               hrdata_d[cmm_pkg::CTRL_HOLD] = hold_q;
            end
            cmm_pkg::REG_STATUS: begin
               hrdata_d[cmm_pkg::ST_BUSY]  = state_q != cmm_pkg::ST_IDLE;
               hrdata_d[cmm_pkg::ST_FAULT] = fault_q;
               hrdata_d[cmm_pkg::ST_PGOOD] = powerGood;
               hrdata_d[cmm_pkg::ST_GRANT +: 3] = grant;
               hrdata_d[cmm_pkg::ST_PULSE +: 5] = pulse_q;
            end
            cmm_pkg::REG_ADDR: begin
               hrdata_d[11:0] = addr_q;
            end
            cmm_pkg::REG_DATA: begin
               hrdata_d[11:0] = zReg_q;
            end
            default: begin
               hrdata_d = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 12'h000;
         hold_q   <= cmm_pkg::CTRL_HOLD_RST;
         hrdata_q <= 32'h00000000;
      end else begin
         wrPend_q <= wrPend_d;
         wrAddr_q <= wrAddr_d;
         hold_q   <= hold_d;
         hrdata_q <= hrdata_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hrdata    = hrdata_q;
   assign hresp     = 1'b0;

   divert_covers_rw_a: assert property (@(posedge clk_sys) disable iff (rst)
      (read_q || write_q) |-> divert_q)
      else $error("Read or write phase outside divert.");

   inhibit_gating_a: assert property (@(posedge clk_sys) disable iff (rst)
      drive_q.inhibit != 12'h000 |->
         inhibit_q && (drive_q.inhibit & wReg_q) == 12'h000)
      else $error("Inhibit active without its conditions.");

   cycle_length_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(state_q == cmm_pkg::ST_RUN) && !fault_q ##127 !fault_q
      |-> pulse_q == 5'd31 && pulseEnd)
      else $error("Storage cycle is not 128 clocks long.");

   diverter_onehot_a: assert property (@(posedge clk_sys) disable iff (rst)
      divert_q |-> $onehot(drive_q.horizDiverterSet)
         && $onehot(drive_q.vertDiverterSet))
      else $error("Diverter selection not one-hot.");

   rw_term_a: assert property (@(posedge clk_sys) disable iff (rst)
      drive_q.horizDriver != 8'h00 |->
         drive_q.readTerm != drive_q.writeTerm)
      else $error("Read and write terms not exclusive.");

   grant_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
      state_q == cmm_pkg::ST_RUN && pulse_q < 5'd26 && !fault_q
      |=> $stable(grant))
      else $error("Grant changed before lock release.");

   start_resync_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(state_q == cmm_pkg::ST_RUN) |-> $past(sel.evenResync))
      else $error("Chain started without resync.");

   fault_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      fault_q ##1 fault_q |-> addr_q == 12'h000 && !divert_q
         && availableN == 3'b111)
      else $error("Fault did not clear controls.");

   path_close_a: assert property (@(posedge clk_sys) disable iff (rst)
      state_q == cmm_pkg::ST_RUN && pulse_q == 5'd24 && tick_q == 2'd1
      |-> !pathEn_q)
      else $error("Data path open after third quarter.");

   run_cycle_c: cover property (@(posedge clk_sys) disable iff (rst)
      state_q == cmm_pkg::ST_RUN && pulse_q == 5'd31 && pulseEnd);
   back_to_back_c: cover property (@(posedge clk_sys) disable iff (rst)
      state_q == cmm_pkg::ST_RUN ##1 state_q == cmm_pkg::ST_WAIT);
   fault_reset_c: cover property (@(posedge clk_sys) disable iff (rst)
      fault_q ##1 !fault_q);

endmodule

// *** testbench/cmm_requester.sv ***
`timescale 1ns/1ps
module cmm_requester #(
   parameter int PHASE = 0
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         want,
   input  wire logic         availN,
   input  wire logic [11:0]  addr,
   output cmm_pkg::cmm_req_s req
);
   logic [4:0] cnt_q;
   logic       sel_q;
   logic       done_q;

   // Select rises only at a quarter boundary and falls once available.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q <= 5'(PHASE);
         sel_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 5'h1;
         if (!availN || !want) begin
            sel_q <= 1'b0;
         end else if (cnt_q == 5'h1f && !done_q) begin
            sel_q <= 1'b1;
         end
         done_q <= want && (done_q || !availN);
      end
   end

   // Lines not in use show a changing pattern, never the last value.
   assign req.select = sel_q;
   assign req.evenResync = (cnt_q == 5'h0);
   assign req.addr = want ? addr : {7'h0, cnt_q};
   assign req.wdata = want ? 12'h5a3 : ~{7'h0, cnt_q};
endmodule

// *** testbench/core_memory_module_control_tb.sv ***
`timescale 1ns/1ps
module core_memory_module_control_tb;
   localparam logic [11:0] ADR = 12'h5ed;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic powerLow = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] want = 3'h0;
   logic [2:0] availableN, resumeN, won, first;
   logic [11:0] readData;
   logic dataPathEn, timingFault, hreadyout, hresp;
   logic [31:0] hrdata;
   cmm_pkg::cmm_req_s [2:0] req;
   cmm_pkg::cmm_drive_s drive;
   int nErrors = 0;
   int checked = 0;
   int cycles = 0;

   // Clock of 50 ns period.
   always #25 clk_sys = ~clk_sys;

   // Requesters sit at different resync phases.
   for (genvar g = 0; g < 3; g++) begin : gReq
      cmm_requester #(.PHASE(g * 5)) req_u (.clk_sys(clk_sys), .rst(rst),
         .want(want[g]), .availN(availableN[g]), .addr(ADR), .req(req[g]));
   end

   cmm_module_control #(.POWER_DELAY_CLKS(20)) dut_u (.clk_sys(clk_sys),
      .rst(rst), .req(req), .senseData(12'h3c6), .powerLow(powerLow),
      .faultResetIn(1'b0), .availableN(availableN), .resumeN(resumeN),
      .readData(readData), .dataPathEn(dataPathEn), .drive(drive),
      .timingFault(timingFault), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

   task automatic results();
      $display("checked %0d errors %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One single transfer; read data is taken at the closing edge.
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
   endtask

   // Bounded wait for a grant to any requester in the mask.
   task automatic waitFor(input logic [2:0] m);
      for (int i = 0; i < 600 && (~availableN & m) === 3'h0; i++)
         @(posedge clk_sys);
      won = ~availableN;
   endtask

   // A hang is cut short well beyond the expected run length.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         nErrors++;
         results();
      end
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      chk("availableN", 32'h7, 32'(availableN));
      chk("fault", 32'h1, 32'(timingFault));
      bus(1'b1, 32'h0, 32'h1);
      repeat (30) @(posedge clk_sys);
      bus(1'b0, 32'h4, 32'h0);
      chk("status", 32'h4, hrdata & 32'h7);
      bus(1'b0, 32'h40, 32'h0);
      chk("unmapped", 32'h0, hrdata);
      want <= 3'h5;
      waitFor(3'h5);
      chk("grants", 32'h1, 32'($countones(won)));
      chk("resume", 32'(availableN), 32'(resumeN));
      for (int i = 0; i < 300 && drive.writeTerm !== 1'b1; i++)
         @(posedge clk_sys);
      chk("hDrv", 32'h04, 32'(drive.horizDriver));
      chk("vDrv", 32'h20, 32'(drive.vertDriver));
      chk("hDiv", 32'h80, 32'(drive.horizDiverterSet));
      chk("vDiv", 32'h20, 32'(drive.vertDiverterSet));
      chk("readTerm", 32'h0, 32'(drive.readTerm));
      chk("inhibit", 32'ha5c, 32'(drive.inhibit));
      chk("readData", 32'h3c6, 32'(readData));
      chk("pathEn", 32'h1, 32'(dataPathEn));
      first = won;
      waitFor(3'h5 ^ first);
      chk("second", 32'(3'h5 ^ first), 32'(won));
      repeat (200) @(posedge clk_sys);
      want <= 3'h0;
      repeat (4) @(posedge clk_sys);
      chk("idle", 32'h7, 32'(availableN));
      powerLow <= 1'b1;
      repeat (40) @(posedge clk_sys);
      chk("powerFault", 32'h1, 32'(timingFault));
      results();
   end
endmodule
